// ---- rtl/vfc_pkg.sv ----
`default_nettype none
package vfc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_MCR1   = 6'h00;
  localparam logic [5:0] IDX_MCR2   = 6'h09;
  localparam logic [5:0] IDX_FIRST  = 6'h0A;
  localparam logic [5:0] IDX_LAST   = 6'h0B;
  localparam logic [5:0] IDX_CTRL   = 6'h0C;
  localparam logic [5:0] IDX_STATUS = 6'h0D;
  localparam logic [7:0] ADR_MCR1   = {IDX_MCR1, 2'b00};
  localparam logic [7:0] ADR_MCR2   = {IDX_MCR2, 2'b00};
  localparam logic [7:0] ADR_FIRST  = {IDX_FIRST, 2'b00};
  localparam logic [7:0] ADR_LAST   = {IDX_LAST, 2'b00};
  localparam logic [7:0] ADR_CTRL   = {IDX_CTRL, 2'b00};
  localparam logic [7:0] ADR_STATUS = {IDX_STATUS, 2'b00};

  // ==========================================================
  // Field positions and reset values
  localparam int MCR1_STALL  = 15;
  localparam int MCR1_CROPF  = 14;
  localparam int MCR2_DEFEAT = 11;
  localparam int MCR2_DRP_HI = 8;
  localparam int MCR2_DRP_LO = 4;
  localparam int CTRL_DEC    = 0;
  localparam int CTRL_PM_LO  = 1;
  localparam int LINE_W      = 10;
  localparam logic [15:0] MCR1_RST = 16'h0000;
  localparam logic [15:0] MCR2_RST = 16'h0000;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [LINE_W-1:0] FIRST_RST = 10'h000;
  localparam logic [LINE_W-1:0] LAST_RST  = 10'h3FF;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ==========================================================
  // Pixel modes and decode state
  typedef enum logic [1:0] {
    PM_BROAD = 2'h0,
    PM_GRAY  = 2'h1,
    PM_656   = 2'h2,
    PM_MUX   = 2'h3
  } vfc_pmode_t;

  typedef enum logic [2:0] {
    ST_PLAY = 3'b001,
    ST_ARM  = 3'b010,
    ST_GRAY = 3'b100
  } vfc_state_t;

  // Raw video pins from the link
  typedef struct packed {
    logic pixelClock;
    logic qualifier;
    logic fieldId;
    logic lineStart;
  } vfc_pins_t;

endpackage
`default_nettype wire

// ---- rtl/vfc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Two-flop synchroniser for pins
module vfc_sync #(
  parameter int W = 4
) (
  input  wire logic         clk, // Sampling clock
  input  wire logic         rst, // Async reset
  input  wire logic [W-1:0] d,   // Pin levels
  output var  logic [W-1:0] q    // Synchronised levels
);
  logic [W-1:0] meta;

  // Metastable stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // vfc_sync
`default_nettype wire

// ---- rtl/vfc_field_ctrl.sv ----
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module vfc_field_ctrl (
  input  wire logic              mclk,          // System clock
  input  wire logic              rst,           // Async reset
  input  wire logic [7:0]        s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write addr valid
  output var  logic              s_axi_awready, // Write addr ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Byte enables
  input  wire logic              s_axi_wvalid,  // Write data valid
  output var  logic              s_axi_wready,  // Write data ready
  output var  logic [1:0]        s_axi_bresp,   // Write response
  output var  logic              s_axi_bvalid,  // Response valid
  input  wire logic              s_axi_bready,  // Response ready
  input  wire logic [7:0]        s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read addr valid
  output var  logic              s_axi_arready, // Read addr ready
  output var  logic [31:0]       s_axi_rdata,   // Read data
  output var  logic [1:0]        s_axi_rresp,   // Read response
  output var  logic              s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire vfc_pkg::vfc_pins_t videoPins,    // Raw video pins
  input  wire logic              hdrValid,      // Header field seen
  input  wire logic              hdrField,      // Header field bit
  output var  logic              pixelStrobe,   // Pixel moves now
  output var  logic              blankLine,     // Line is cropped
  output var  logic              grayField,     // Gray field out
  output var  logic              fieldSend,     // Field is encoded
  output var  logic              fieldStart     // Field began
);
  import vfc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // State
  logic [15:0]       mcr1, next_mcr1, mcr2, next_mcr2;
  logic [LINE_W-1:0] firstLine, next_firstLine, lastLine, next_lastLine;
  logic [2:0]        ctrl, next_ctrl;
  logic              awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0]        awAddr, next_awAddr;
  logic [31:0]       wData, next_wData;
  logic [3:0]        wStrb, next_wStrb;
  logic              next_awready, next_wready, next_bvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic              next_arready, next_rvalid;
  logic [31:0]       next_rdata;
  logic [3:0]        sPins;
  logic              prevClk, next_prevClk, curField, next_curField;
  logic              prevLine, next_prevLine;
  logic [LINE_W-1:0] line, next_line;
  logic [4:0]        dropCnt, next_dropCnt;
  vfc_state_t        state, next_state;
  logic              next_pixelStrobe, next_blankLine;
  logic              next_grayField, next_fieldSend, next_fieldStart;
  logic              tick, fieldEdge, lineEdge, needQual;
  logic              decode, cropField, defeat, mismatch;
  vfc_pmode_t        pmode;

  // ==========================================================
  // Register decode and status read
  function automatic logic [31:0] readMux(input logic [7:0] a);
    if (a == ADR_MCR1) begin
      readMux = 32'h0000_0000;
    end else if (a == ADR_MCR2) begin
      readMux = {16'h0000, mcr2};
    end else if (a == ADR_FIRST) begin
      readMux = {22'h00_0000, firstLine};
    end else if (a == ADR_LAST) begin
      readMux = {22'h00_0000, lastLine};
    end else if (a == ADR_CTRL) begin
      readMux = {29'h0000_0000, ctrl};
    end else begin
      readMux = {16'h0000, state, grayField, fieldSend, curField, line};
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADR_MCR1) || (a == ADR_MCR2) || (a == ADR_FIRST) ||
             (a == ADR_LAST) || (a == ADR_CTRL) || (a == ADR_STATUS);
  endfunction

  // AXI4-Lite slave: address and data in either order
  always_comb begin
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_arready = s_axi_arready;
    next_mcr1      = mcr1;
    next_mcr2      = mcr2;
    next_firstLine = firstLine;
    next_lastLine  = lastLine;
    next_ctrl      = ctrl;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = RESP_OK;
      if (awAddr == ADR_MCR1) begin
        next_mcr1 = merge16(mcr1, wData, wStrb);
      end else if (awAddr == ADR_MCR2) begin
        next_mcr2 = merge16(mcr2, wData, wStrb);
      end else if (awAddr == ADR_FIRST) begin
        next_firstLine = LINE_W'(merge16(16'(firstLine), wData, wStrb));
      end else if (awAddr == ADR_LAST) begin
        next_lastLine = LINE_W'(merge16(16'(lastLine), wData, wStrb));
      end else if (awAddr == ADR_CTRL) begin
        if (wStrb[0]) begin
          next_ctrl = wData[2:0];
        end
      end else begin
        next_bresp = RESP_ERR; // Status and holes refuse writes
      end
    end
    next_awready = !next_awHeld && !next_bvalid;
    next_wready  = !next_wHeld && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid  = 1'b1;
      next_arready = 1'b0;
      next_rdata   = readMux(s_axi_araddr);
      next_rresp   = mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
    end
  end

  // Bus and control registers, off at power-up except LAST (3FF) and the bus readies (high)
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mcr1          <= MCR1_RST;
      mcr2          <= MCR2_RST;
      firstLine     <= FIRST_RST;
      lastLine      <= LAST_RST;
      ctrl          <= CTRL_RST;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      mcr1          <= next_mcr1;
      mcr2          <= next_mcr2;
      firstLine     <= next_firstLine;
      lastLine      <= next_lastLine;
      ctrl          <= next_ctrl;
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      awAddr        <= next_awAddr;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ==========================================================
  // Video link: pins pass two flops, then edges are found
  vfc_sync #(.W(4)) uSync (
    .clk (mclk),
    .rst (rst),
    .d   (videoPins),
    .q   (sPins)
  );

  // Field-level controls taken from the registers, edges taken from the pins
  assign decode    = ctrl[CTRL_DEC];
  assign pmode     = vfc_pmode_t'(ctrl[CTRL_PM_LO +: 2]);
  assign cropField = mcr1[MCR1_CROPF];
  assign defeat    = mcr2[MCR2_DEFEAT];
  assign tick      = sPins[3] && !prevClk;
  assign fieldEdge = tick && (sPins[1] != curField);
  assign lineEdge  = tick && sPins[0] && !prevLine;
  // Qualifier gates pixels in half-rate modes or under stall
  assign needQual  = (pmode == PM_BROAD) || (pmode == PM_GRAY) ||
                     mcr1[MCR1_STALL];
  // Header field bit must name the field about to start
  assign mismatch  = hdrValid && decode && !defeat &&
                     (hdrField != !curField);

  // Line counting, cropping, gray insertion and field dropping
  always_comb begin
    next_prevClk     = tick ? 1'b1 : sPins[3];
    next_curField    = tick ? sPins[1] : curField;
    next_prevLine    = tick ? sPins[0] : prevLine;
    next_line        = line;
    next_dropCnt     = dropCnt;
    next_state       = state;
    next_fieldSend   = fieldSend;
    next_pixelStrobe = tick && (!needQual || sPins[2]);
    next_fieldStart  = fieldEdge;
    if (fieldEdge) begin
      // Frame mode restarts only at field one
      if (cropField || !sPins[1]) begin
        next_line = '0;
      end
    end else if (lineEdge && line != '1) begin
      next_line = line + 1'b1;
    end
    case (state)
      ST_PLAY: begin
        if (mismatch) begin
          next_state = ST_ARM;
        end
      end
      ST_ARM: begin
        if (fieldEdge) begin
          next_state = ST_GRAY;
        end
      end
      ST_GRAY: begin
        if (fieldEdge) begin
          next_state = ST_PLAY;
        end
      end
      default: next_state = ST_PLAY;
    endcase
    if (!decode && fieldEdge) begin
      if (dropCnt == 5'h00) begin
        next_fieldSend = 1'b1;
        next_dropCnt   = mcr2[MCR2_DRP_HI:MCR2_DRP_LO];
      end else begin
        next_fieldSend = 1'b0;
        next_dropCnt   = dropCnt - 5'h01;
      end
    end else if (decode) begin
      next_fieldSend = 1'b1;
      next_dropCnt   = 5'h00;
    end
    next_grayField = (state == ST_GRAY);
    next_blankLine = (line < firstLine) || (line > lastLine) ||
                     (!cropField && curField);
  end

  // Video-side registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prevClk     <= 1'b0;
      curField    <= 1'b0;
      prevLine    <= 1'b0;
      line        <= '0;
      dropCnt     <= 5'h00;
      state       <= ST_PLAY;
      pixelStrobe <= 1'b0;
      blankLine   <= 1'b1;
      grayField   <= 1'b0;
      fieldSend   <= 1'b1;
      fieldStart  <= 1'b0;
    end else begin
      prevClk     <= next_prevClk;
      curField    <= next_curField;
      prevLine    <= next_prevLine;
      line        <= next_line;
      dropCnt     <= next_dropCnt;
      state       <= next_state;
      pixelStrobe <= next_pixelStrobe;
      blankLine   <= next_blankLine;
      grayField   <= next_grayField;
      fieldSend   <= next_fieldSend;
      fieldStart  <= next_fieldStart;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_stall;
    pixelStrobe && $past(needQual) |-> $past(sPins[2]);
  endproperty
  a_stall: assert property (p_stall) else $error("stall not kept");
  property p_reset;
    disable iff (1'b0) $past(rst) |-> mcr1 == MCR1_RST && mcr2 == MCR2_RST;
  endproperty
  a_reset: assert property (p_reset)
    else $error("mode controls not off after reset");
  property p_gray;
    state == ST_ARM && fieldEdge |=> state == ST_GRAY ##1 grayField;
  endproperty
  a_gray: assert property (p_gray) else $error("no gray field");
  property p_defeat;
    state == ST_PLAY && defeat |=> state == ST_PLAY;
  endproperty
  a_defeat: assert property (p_defeat) else $error("gray armed");
  property p_frame;
    !cropField && curField |=> blankLine;
  endproperty
  a_frame: assert property (p_frame) else $error("field two seen");
  property p_field;
    cropField && line >= firstLine && line <= lastLine |=> !blankLine;
  endproperty
  a_field: assert property (p_field) else $error("line blanked");
  property p_drop;
    !decode && fieldEdge && dropCnt != 5'h00 |=> !fieldSend &&
      dropCnt == $past(dropCnt) - 5'h01;
  endproperty
  a_drop: assert property (p_drop) else $error("drop ignored");
  property p_rd2;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADR_MCR2
      |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(mcr2);
  endproperty
  a_rd2: assert property (p_rd2) else $error("bad mode read");
  property p_wo1;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADR_MCR1
      |=> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_wo1: assert property (p_wo1) else $error("write-only read");
endmodule // vfc_field_ctrl
`default_nettype wire

// ---- verification/vfc_video_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Raw video source standing on the far side of the pixel link
module vfc_video_src (
  output var vfc_pkg::vfc_pins_t pins // Pixel link pins
);
  import vfc_pkg::*;
  // Clock stands still and qualifier stays low before first field
  initial begin
    pins = '0;
  end
  // One video clock, pins set up half a period before its edge
  task automatic tick(input logic q, input logic f, input logic ls);
    pins.qualifier = q;
    pins.fieldId = f;
    pins.lineStart = ls;
    #32 pins.pixelClock = 1'b1;
    #32 pins.pixelClock = 1'b0;
  endtask
endmodule // vfc_video_src
`default_nettype wire

// ---- verification/vfc_field_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module vfc_field_ctrl_tb;
  import vfc_pkg::*;
  logic        mclk, rst, hdrValid, hdrField;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        pixelStrobe, blankLine, grayField, fieldSend, fieldStart;
  vfc_pins_t   videoPins;
  int          err_total, n_checks, strobes, starts;
  logic [31:0] qc [6] = '{32'h0, 32'h2, 32'h4, 32'h4, 32'h6, 32'h6};
  logic [31:0] qm [6] = '{32'h0, 32'h0, 32'h0, 32'h8000, 32'h8000, 32'h0};
  int          qe [6] = '{4, 4, 8, 4, 4, 8};

  // ==========================================================
  // Clock, design and video source
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  vfc_field_ctrl vfc_field_ctrl_inst (.mclk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .videoPins,
    .hdrValid, .hdrField, .pixelStrobe, .blankLine, .grayField,
    .fieldSend, .fieldStart);
  vfc_video_src vfc_video_src_inst (.pins(videoPins));
  // Counts pixel strobes and field starts seen
  always @(posedge mclk) begin
    if (pixelStrobe === 1'b1) strobes <= strobes + 1;
    if (fieldStart === 1'b1) starts <= starts + 1;
  end

  // ==========================================================
  // Report helpers
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tmo;
    err_total++;
    $display("BAD bus answer expected 1 seen 0");
    complete_run();
  endtask

  // ==========================================================
  // Bus master: valid held until its ready is sampled high
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40 && !b; i++) begin
      @(negedge mclk);
      aw = s_axi_awvalid && s_axi_awready === 1'b1;
      w = s_axi_wvalid && s_axi_wready === 1'b1;
      b = s_axi_bvalid === 1'b1;
      rsp = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) tmo();
  endtask
  task automatic axr(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40 && !r; i++) begin
      @(negedge mclk);
      ar = s_axi_arvalid && s_axi_arready === 1'b1;
      r = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    if (!r) tmo();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_qual;
    int s0;
    for (int k = 0; k < 6; k++) begin
      axw(ADR_CTRL, qc[k]);
      if (k > 2) axw(ADR_MCR1, qm[k]);
      s0 = strobes;
      for (int j = 0; j < 8; j++) vfc_video_src_inst.tick(j[0], 1'b1, 1'b0);
      repeat (6) @(posedge mclk);
      s0 = strobes - s0;
      chk("strobes", 32'(qe[k]), 32'(s0));
    end
    $display("qualifier test done");
  endtask
  task automatic t_regs;
    axr(ADR_MCR2);
    chk("mcr2 reset", 32'h0, rd);
    axw(ADR_MCR1, 32'h0000C000);
    axr(ADR_MCR1);
    chk("mcr1 read", 32'h0, rd);
    axw(ADR_MCR1, 32'h0);
    axw(ADR_MCR2, 32'h00000920);
    chk("mcr2 wr resp", {30'h0, RESP_OK}, {30'h0, rsp});
    axr(ADR_MCR2);
    chk("mcr2 read", 32'h920, rd);
    s_axi_wstrb <= 4'h1;
    axw(ADR_MCR2, 32'h0000FFFF);
    s_axi_wstrb <= 4'hF;
    axr(ADR_MCR2);
    chk("mcr2 lane", 32'h9FF, rd);
    axw(ADR_STATUS, 32'h1);
    chk("status wr resp", {30'h0, RESP_ERR}, {30'h0, rsp});
    axr(8'hFC);
    chk("unmapped resp", {30'h0, RESP_ERR}, {30'h0, rsp});
    axw(ADR_MCR2, 32'h0);
    $display("register test done");
  endtask
  task automatic t_crop(input logic fm);
    logic e;
    axw(ADR_MCR1, fm ? 32'h4000 : 32'h0);
    for (int f = 0; f < 2; f++) begin
      vfc_video_src_inst.tick(1'b1, f[0], 1'b0);
      for (int l = 1; l < 5; l++) begin
        vfc_video_src_inst.tick(1'b1, f[0], 1'b1);
        vfc_video_src_inst.tick(1'b1, f[0], 1'b0);
        repeat (4) @(posedge mclk);
        e = l < 2 || l > 3 || (f == 1 && !fm);
        chk("blank", {31'h0, e}, {31'h0, blankLine});
      end
    end
    $display("crop test done");
  endtask
  task automatic t_drop;
    logic f;
    int s0;
    axw(ADR_CTRL, 32'h0);
    axw(ADR_MCR2, 32'h20);
    for (int k = 0; k < 6; k++) begin
      f = videoPins.fieldId;
      s0 = starts;
      vfc_video_src_inst.tick(1'b1, !f, 1'b0);
      repeat (4) @(posedge mclk);
      chk("send", 32'(k % 3 == 0), {31'h0, fieldSend});
      chk("starts", 32'h1, 32'(starts - s0));
    end
    $display("drop test done");
  endtask
  task automatic t_gray;
    logic f;
    axw(ADR_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      axw(ADR_MCR2, k == 2 ? 32'h800 : 32'h0);
      f = videoPins.fieldId;
      @(posedge mclk);
      hdrValid <= 1'b1;
      hdrField <= k == 1 ? !f : f;
      @(posedge mclk);
      hdrValid <= 1'b0;
      vfc_video_src_inst.tick(1'b1, !f, 1'b0);
      repeat (4) @(posedge mclk);
      chk("gray", 32'(k == 0), {31'h0, grayField});
      vfc_video_src_inst.tick(1'b1, f, 1'b0);
      repeat (4) @(posedge mclk);
      chk("gray end", 32'h0, {31'h0, grayField});
    end
    $display("gray test done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {hdrValid, hdrField, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {err_total, n_checks, strobes, starts} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_qual();
    t_regs();
    axw(ADR_FIRST, 32'h2);
    axw(ADR_LAST, 32'h3);
    t_crop(1'b0);
    t_crop(1'b1);
    t_drop();
    t_gray();
    complete_run();
  end
endmodule // vfc_field_ctrl_tb
`default_nettype wire
